// ===== rtl/sdlc_pkg.sv
/*
  sdlc_pkg: shared constants for the synthesizer divider and lock control ends.
  assumes: both ends run on one 100 MHz clock; serial pins are synchronous to it.
*/
package sdlc_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 10;

  // word layout
  localparam int WORD_W    = 32;
  localparam int SEL_MSB   = 2;
  localparam int SEL_LSB   = 0;
  localparam logic [2:0] SEL_R0 = 3'h0;
  localparam logic [2:0] SEL_R1 = 3'h1;
  localparam logic [2:0] SEL_R2 = 3'h2;
  localparam logic [2:0] SEL_R3 = 3'h3;
  localparam logic [2:0] SEL_R4 = 3'h4;

  // register zero
  localparam int INT_MSB  = 30;
  localparam int INT_LSB  = 15;
  localparam int FRACTION_NUMERATOR_MSB = 14;
  localparam int FRACTION_NUMERATOR_LSB = 3;
  // register one
  localparam int PRESC_BIT = 27;
  localparam int PHASE_MSB = 26;
  localparam int PHASE_LSB = 15;
  localparam int MOD_MSB   = 14;
  localparam int MOD_LSB   = 3;
  localparam logic PRESC_45 = 1'b0;
  localparam logic PRESC_89 = 1'b1;
  // register two
  localparam int NOISE_MSB = 30;
  localparam int NOISE_LSB = 29;
  localparam int MUX_MSB   = 28;
  localparam int MUX_LSB   = 26;
  localparam int DBL_BIT   = 25;
  localparam int HALVE_BIT = 24;
  localparam int RCNT_MSB  = 23;
  localparam int RCNT_LSB  = 14;
  localparam int DBUF_BIT  = 13;
  localparam int CP_MSB    = 11;
  localparam int CP_LSB    = 9;
  localparam int LDF_BIT   = 8;
  localparam int LDP_BIT   = 7;
  localparam int PD_BIT    = 5;
  localparam int TRI_BIT   = 4;
  localparam int CRST_BIT  = 3;
  localparam logic [1:0] NOISE_LOW_NOISE = 2'h0;
  localparam logic [1:0] NOISE_LOW_SPUR  = 2'h3;
  // register three
  localparam int BOOST_BIT = 18;
  // register four
  localparam int DIVSEL_MSB = 22;
  localparam int DIVSEL_LSB = 20;

  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // integer floor per prescaler
  localparam logic [15:0] N_MIN_45 = 16'h0017;
  localparam logic [15:0] N_MIN_89 = 16'h004b;

  // lock detector
  localparam logic [5:0] LOCK_CYC_SLOW = 6'h28;
  localparam logic [5:0] LOCK_CYC_FAST = 6'h05;
  localparam int WIN_WIDE_NS   = 10;
  localparam int WIN_NARROW_NS = 6;
  // longest times round down, never below one cycle
  localparam int WIN_WIDE_CYC_I   = (WIN_WIDE_NS / CLK_PERIOD_NS < 1) ? 1 : WIN_WIDE_NS / CLK_PERIOD_NS;
  localparam int WIN_NARROW_CYC_I = (WIN_NARROW_NS / CLK_PERIOD_NS < 1) ? 1 : WIN_NARROW_NS / CLK_PERIOD_NS;
  localparam logic [3:0] WIN_WIDE_CYC   = 4'(WIN_WIDE_CYC_I);
  localparam logic [3:0] WIN_NARROW_CYC = 4'(WIN_NARROW_CYC_I);

  // host register map
  localparam logic [7:0] ADDR_WORD   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int ST_BUSY    = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_OVERRUN = 2;

  // serial clock half period in CLK cycles
  localparam logic [3:0] SCLK_HALF = 4'h2;
  localparam logic [4:0] LAST_BIT  = 5'h1f;

  typedef enum logic [2:0] {
    SDLC_IDLE  = 3'b001,
    SDLC_SHIFT = 3'b010,
    SDLC_LATCH = 3'b100
  } sdlc_host_state_type;
endpackage

// ===== rtl/sdlc_if.sv
/*
  sdlc_if: three-wire serial link between host controller and device.
  assumes: host drives all three wires; the device only listens.
*/
`timescale 1ns/10ps
interface sdlc_if;
  logic sclk;
  logic sdata;
  logic le;
  modport dev  (input  sclk, input  sdata, input  le);
  modport host (output sclk, output sdata, output le);
endinterface

// ===== rtl/sdlc_device.sv
/*
  sdlc_device: serial register bank, reference path and digital lock detector.
  assumes: serial pins, reference and feedback inputs are synchronous to CLK and
  each stay at a level for at least one CLK cycle.
*/
`timescale 1ns/10ps
// Summary of operation
// - bit 27 register one picks 4/5 or 8/9
// - host keeps integer at least 23 or 75
// - host picks 8/9 above 3 GHz
// - phase word bits 26:15, below modulus
// - modulus in bits 14:3 of register one
// - control bits 010, 011 load registers two, three
// - noise mode bits 30:29; low spur dithers
// - bits 28:26 pick test output source
// - doubler off: falling edge only, on: both edges
// - bit 24 adds toggle halving before detector
// - ten-bit reference divider, ratios 1 to 1023
// - bit 13 double-buffers divider select bits
// - bits 11:9 set charge pump current
// - bit 8: 40 or 5 monitored cycles
// - bit 7: 10 ns or 6 ns window
// - lock only after n consecutive in-window cycles
// - host uses recommended count and window pairs
// - bit 5 powers down, registers retained
// - power-down: counters load, pump off, lock reset
// - bit 4 three-states the charge pump
// - bit 3 holds both counters in reset
// - bit 18 boost current until near lock
// - buffered fields apply on register zero write
module sdlc_device
  import sdlc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // serial link
  sdlc_if.dev              SER,
  // analog side inputs
  input  wire logic        REF_IN,
  input  wire logic        FB_IN,
  // divider settings
  output logic [15:0]      INT_VALUE,
  output logic [11:0]      FRACTION_NUMERATOR_VALUE,
  output logic [11:0]      PHASE_WORD,
  output logic [11:0]      FRACTION_MODULUS,
  output logic             PRESCALER_RATIO_SELECT,
  output logic [2:0]       OUT_DIVIDER_SELECT,
  // loop controls
  output logic             DITHER_ENABLE,
  output logic [2:0]       TEST_OUTPUT_SELECT,
  output logic [2:0]       CP_CURRENT,
  output logic             CP_THREE_STATE,
  output logic             BOOST_CURRENT_ON,
  output logic             COUNTER_HOLD,
  output logic             OUTPUT_BUFFER_OFF,
  // detector side
  output logic             PFD_REF_PULSE,
  output logic             LOCK_DETECT
);
  // serial capture
  logic        sclk_d_r;
  logic        le_d_r;
  logic [31:0] shift_r;
  // programmed words and live copies
  logic [31:0] r1_r;
  logic [31:0] r2_r;
  logic [31:0] r3_r;
  logic [2:0]  divsel_shadow_r;
  logic [11:0] phase_act_r;
  logic [11:0] mod_act_r;
  logic        dbl_act_r;
  logic        halve_act_r;
  logic [9:0]  rcnt_act_r;
  // reference path
  logic        ref_d_r;
  logic        fb_d_r;
  logic [9:0]  rcnt_r;
  logic        toggle_r;
  // lock detector
  logic        pend_r;
  logic        pend_ref_r;
  logic [3:0]  gap_r;
  logic [5:0]  good_cnt_r;
  logic        lock_r;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  logic        sclk_rise;
  logic        latch_now;
  logic [2:0]  sel;
  logic        pd;
  logic        hold;
  logic        ref_evt;
  logic        r_wrap;
  logic        pfd_evt;
  logic        fb_evt;
  logic [3:0]  win;
  logic [5:0]  need;
  logic        good;
  logic        bad;

  assign sclk_rise = rise(SER.sclk, sclk_d_r);
  assign latch_now = rise(SER.le, le_d_r);
  assign sel       = shift_r[SEL_MSB:SEL_LSB];
  assign pd        = r2_r[PD_BIT];
  assign hold      = pd | r2_r[CRST_BIT];
  // doubler off: falling reference edge only; on: both edges
  assign ref_evt   = dbl_act_r ? (REF_IN ^ ref_d_r) : rise(ref_d_r, REF_IN);
  assign r_wrap    = ref_evt & (rcnt_r + 10'h001 >= rcnt_act_r);
  assign pfd_evt   = halve_act_r ? (r_wrap & toggle_r) : r_wrap;
  assign fb_evt    = rise(FB_IN, fb_d_r);
  assign win       = r2_r[LDP_BIT] ? WIN_NARROW_CYC : WIN_WIDE_CYC;
  assign need      = r2_r[LDF_BIT] ? LOCK_CYC_FAST : LOCK_CYC_SLOW;

  // serial input stays live in power-down
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_d_r <= 1'b0;
      le_d_r   <= 1'b0;
      shift_r  <= WORD_RST;
    end else begin
      sclk_d_r <= SER.sclk;
      le_d_r   <= SER.le;
      if (sclk_rise) begin
        shift_r <= {shift_r[WORD_W-2:0], SER.sdata};
      end
    end
  end

  // register loads and double-buffer transfer
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      r1_r            <= WORD_RST;
      r2_r            <= WORD_RST;
      r3_r            <= WORD_RST;
      divsel_shadow_r <= 3'h0;
      INT_VALUE       <= 16'h0000;
      FRACTION_NUMERATOR_VALUE      <= 12'h000;
      phase_act_r     <= 12'h000;
      mod_act_r       <= 12'h000;
      dbl_act_r       <= 1'b0;
      halve_act_r     <= 1'b0;
      rcnt_act_r      <= 10'h000;
      OUT_DIVIDER_SELECT <= 3'h0;
    end else if (latch_now) begin
      if (sel == SEL_R0) begin
        INT_VALUE   <= shift_r[INT_MSB:INT_LSB];
        FRACTION_NUMERATOR_VALUE  <= shift_r[FRACTION_NUMERATOR_MSB:FRACTION_NUMERATOR_LSB];
        phase_act_r <= r1_r[PHASE_MSB:PHASE_LSB];
        mod_act_r   <= r1_r[MOD_MSB:MOD_LSB];
        dbl_act_r   <= r2_r[DBL_BIT];
        halve_act_r <= r2_r[HALVE_BIT];
        rcnt_act_r  <= r2_r[RCNT_MSB:RCNT_LSB];
        if (r2_r[DBUF_BIT]) begin
          OUT_DIVIDER_SELECT <= divsel_shadow_r;
        end
      end else if (sel == SEL_R1) begin
        r1_r <= shift_r;
      end else if (sel == SEL_R2) begin
        r2_r <= shift_r;
      end else if (sel == SEL_R3) begin
        r3_r <= shift_r;
      end else if (sel == SEL_R4) begin
        divsel_shadow_r <= shift_r[DIVSEL_MSB:DIVSEL_LSB];
        if (!r2_r[DBUF_BIT]) begin
          OUT_DIVIDER_SELECT <= shift_r[DIVSEL_MSB:DIVSEL_LSB];
        end
      end
    end
  end

  // reference divider and halving stage; hold forces the load state
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_d_r       <= 1'b0;
      fb_d_r        <= 1'b0;
      rcnt_r        <= 10'h000;
      toggle_r      <= 1'b0;
      PFD_REF_PULSE <= 1'b0;
    end else begin
      ref_d_r <= REF_IN;
      fb_d_r  <= FB_IN;
      if (hold) begin
        rcnt_r        <= 10'h000;
        toggle_r      <= 1'b0;
        PFD_REF_PULSE <= 1'b0;
      end else begin
        PFD_REF_PULSE <= pfd_evt;
        if (r_wrap) begin
          rcnt_r   <= 10'h000;
          toggle_r <= ~toggle_r;
        end else if (ref_evt) begin
          rcnt_r <= rcnt_r + 10'h001;
        end
      end
    end
  end

  // pair a reference edge with a feedback edge; a gap beyond the window fails the cycle
  always_comb begin
    good = 1'b0;
    bad  = 1'b0;
    if (pfd_evt & fb_evt) begin
      good = 1'b1;
    end else if (pend_r && ((pfd_evt && !pend_ref_r) || (fb_evt && pend_ref_r))) begin
      good = (gap_r <= win);
      bad  = (gap_r > win);
    end else if (pend_r && (pfd_evt || fb_evt)) begin
      bad = 1'b1;
    end else if (pend_r && gap_r >= win) begin
      bad = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_r     <= 1'b0;
      pend_ref_r <= 1'b0;
      gap_r      <= 4'h0;
      good_cnt_r <= 6'h00;
      lock_r     <= 1'b0;
    end else if (hold) begin
      pend_r     <= 1'b0;
      gap_r      <= 4'h0;
      good_cnt_r <= 6'h00;
      lock_r     <= 1'b0;
    end else begin
      if (good || (pend_r && !pfd_evt && !fb_evt && bad)) begin
        pend_r <= 1'b0;
        gap_r  <= 4'h0;
      end else if (pfd_evt || fb_evt) begin
        // an unpaired edge opens a new pair
        pend_r     <= 1'b1;
        pend_ref_r <= pfd_evt;
        gap_r      <= 4'h0;
      end else if (pend_r) begin
        gap_r <= gap_r + 4'h1;
      end
      if (bad) begin
        good_cnt_r <= 6'h00;
        lock_r     <= 1'b0;
      end else if (good) begin
        if (good_cnt_r < need) begin
          good_cnt_r <= good_cnt_r + 6'h01;
        end
        lock_r <= (good_cnt_r + 6'h01 >= need);
      end
    end
  end

  // registered control outputs
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PHASE_WORD             <= 12'h000;
      FRACTION_MODULUS       <= 12'h000;
      PRESCALER_RATIO_SELECT <= PRESC_45;
      DITHER_ENABLE          <= 1'b0;
      TEST_OUTPUT_SELECT     <= 3'h0;
      CP_CURRENT             <= 3'h0;
      CP_THREE_STATE         <= 1'b0;
      BOOST_CURRENT_ON       <= 1'b0;
      COUNTER_HOLD           <= 1'b0;
      OUTPUT_BUFFER_OFF      <= 1'b0;
      LOCK_DETECT            <= 1'b0;
    end else begin
      PHASE_WORD             <= phase_act_r;
      FRACTION_MODULUS       <= mod_act_r;
      PRESCALER_RATIO_SELECT <= r1_r[PRESC_BIT];
      DITHER_ENABLE          <= (r2_r[NOISE_MSB:NOISE_LSB] == NOISE_LOW_SPUR);
      TEST_OUTPUT_SELECT     <= r2_r[MUX_MSB:MUX_LSB];
      CP_CURRENT             <= r2_r[CP_MSB:CP_LSB];
      CP_THREE_STATE         <= r2_r[TRI_BIT] | pd;
      // lock stands in for the tuning voltage nearing its final value
      BOOST_CURRENT_ON       <= r3_r[BOOST_BIT] & ~lock_r & ~hold;
      COUNTER_HOLD           <= hold;
      OUTPUT_BUFFER_OFF      <= pd;
      LOCK_DETECT            <= lock_r;
    end
  end
endmodule

// ===== rtl/sdlc_host.sv
/*
  sdlc_host: APB slave that sends 32-bit words over the three-wire link.
  assumes: APB on CLK; the device samples data on the serial clock rising edge.
*/
`timescale 1ns/10ps
module sdlc_host
  import sdlc_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial link
  sdlc_if.host             SER
);
  sdlc_host_state_type state_r;
  logic [31:0] word_r;
  logic [4:0]  bit_r;
  logic [3:0]  half_r;
  logic        sclk_r;
  logic        sdata_r;
  logic        le_r;
  logic        presc_r;
  logic        refused_r;
  logic        overrun_r;

  logic        setup;
  logic        wr;
  logic        start;
  logic        legal;
  logic        half_done;
  logic [15:0] n_min;

  assign setup     = PSEL & ~PENABLE;
  assign wr        = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign half_done = (half_r + 4'h1 >= SCLK_HALF);
  assign n_min     = presc_r ? N_MIN_89 : N_MIN_45;

  // screen words that would break the device's limits
  always_comb begin
    legal = 1'b1;
    if (PWDATA[SEL_MSB:SEL_LSB] == SEL_R0) begin
      legal = (PWDATA[INT_MSB:INT_LSB] >= n_min);
    end else if (PWDATA[SEL_MSB:SEL_LSB] == SEL_R1) begin
      legal = (PWDATA[PHASE_MSB:PHASE_LSB] < PWDATA[MOD_MSB:MOD_LSB]);
    end
  end
  assign start = wr && (PADDR == ADDR_WORD) && (state_r == SDLC_IDLE) && legal;

  // apb answer is registered: ready in the first access cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & (PADDR != ADDR_WORD) & (PADDR != ADDR_STATUS);
      PRDATA  <= 32'h0000_0000;
      if (setup && !PWRITE) begin
        if (PADDR == ADDR_WORD) begin
          PRDATA <= word_r;
        end else if (PADDR == ADDR_STATUS) begin
          PRDATA[ST_BUSY]    <= (state_r != SDLC_IDLE);
          PRDATA[ST_REFUSED] <= refused_r;
          PRDATA[ST_OVERRUN] <= overrun_r;
        end
      end
    end
  end

  // sticky flags: a new refusal wins over a write-one clear in the same cycle
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      refused_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      if (wr && PADDR == ADDR_WORD && state_r == SDLC_IDLE && !legal) begin
        refused_r <= 1'b1;
      end else if (wr && PADDR == ADDR_STATUS && PWDATA[ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
      if (wr && PADDR == ADDR_WORD && state_r != SDLC_IDLE) begin
        overrun_r <= 1'b1;
      end else if (wr && PADDR == ADDR_STATUS && PWDATA[ST_OVERRUN]) begin
        overrun_r <= 1'b0;
      end
    end
  end

  // prescaler mirror for the integer floor check
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      presc_r <= PRESC_45;
    end else if (start && PWDATA[SEL_MSB:SEL_LSB] == SEL_R1) begin
      presc_r <= PWDATA[PRESC_BIT];
    end
  end

  // shifter: msb first, data set while clock low, then a latch pulse
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= SDLC_IDLE;
      word_r  <= WORD_RST;
      bit_r   <= 5'h00;
      half_r  <= 4'h0;
      sclk_r  <= 1'b0;
      sdata_r <= 1'b0;
      le_r    <= 1'b0;
    end else begin
      case (state_r)
        SDLC_IDLE: begin
          if (start) begin
            word_r  <= PWDATA;
            sdata_r <= PWDATA[WORD_W-1];
            bit_r   <= 5'h00;
            half_r  <= 4'h0;
            state_r <= SDLC_SHIFT;
          end
        end
        SDLC_SHIFT: begin
          half_r <= half_done ? 4'h0 : half_r + 4'h1;
          if (half_done) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              if (bit_r == LAST_BIT) begin
                le_r    <= 1'b1;
                state_r <= SDLC_LATCH;
              end else begin
                bit_r   <= bit_r + 5'h01;
                sdata_r <= word_r[5'(LAST_BIT - bit_r - 5'h01)];
              end
            end
          end
        end
        SDLC_LATCH: begin
          half_r <= half_done ? 4'h0 : half_r + 4'h1;
          if (half_done) begin
            le_r    <= 1'b0;
            state_r <= SDLC_IDLE;
          end
        end
        default: begin
          state_r <= SDLC_IDLE;
        end
      endcase
    end
  end

  assign SER.sclk  = sclk_r;
  assign SER.sdata = sdata_r;
  assign SER.le    = le_r;
endmodule

// ===== testbench/sdlc_link_props.sv
/*
  sdlc_link_props: framing checks on the three-wire link between the two ends.
  assumes: instantiated beside the link interface; one clock, reset active low.
*/
`timescale 1ns/10ps
module sdlc_link_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // link wires
  input wire logic sclk,
  input wire logic sdata,
  input wire logic le
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  logic       sclk_d_r;
  logic [5:0] bit_cnt_r;

  // cleared by le, so a latched word can never leak bits into the next frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sclk_d_r  <= 1'b0;
      bit_cnt_r <= 6'h00;
    end else begin
      sclk_d_r <= sclk;
      if (le) begin
        bit_cnt_r <= 6'h00;
      end else if (sclk && !sclk_d_r) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  sequence s_high2;
    sclk ##1 sclk ##1 !sclk;
  endsequence
  sequence s_latch;
    le ##1 le ##1 !le;
  endsequence

  AST_LE_PULSE: assert property ($rose(le) |-> s_latch)
    else $error("latch pulse not two cycles");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high2)
    else $error("serial clock high phase wrong");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk ##1 !sclk)
    else $error("serial clock low phase too short");
  AST_DATA_HOLD: assert property (sclk |-> $stable(sdata))
    else $error("data moved while serial clock high");
  AST_LE_NO_SCLK: assert property (le |-> !sclk)
    else $error("serial clock high during latch");
  AST_LE_FULL_WORD: assert property ($rose(le) |-> bit_cnt_r == 6'h20)
    else $error("latch without exactly 32 bits");
  AST_CNT_BOUND: assert property (bit_cnt_r <= 6'h20)
    else $error("more than 32 bits in one frame");
  // the latch rises on the very edge that drops the last serial clock
  AST_LAST_TO_LE: assert property ($fell(sclk) && bit_cnt_r == 6'h20 |-> $rose(le))
    else $error("no latch after last bit");
  AST_NEXT_BIT: assert property ($fell(sclk) && bit_cnt_r < 6'h20 |-> ##[1:4] $rose(sclk))
    else $error("frame stalled between bits");
endmodule

// ===== testbench/testbench.sv
/*
  testbench: apb host end drives the device end over the link; a word model gives expectations.
  assumes: package, interface, both ends and the link checker are compiled first.
*/
`timescale 1ns/10ps
module testbench import sdlc_pkg::*;;
  logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, REF_IN, FB_IN, q_err;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q, m_r2, m_r3;
  logic [15:0] INT_VALUE;
  logic [11:0] FRACTION_NUMERATOR_VALUE, PHASE_WORD, FRACTION_MODULUS;
  logic [2:0]  OUT_DIVIDER_SELECT, TEST_OUTPUT_SELECT, CP_CURRENT;
  logic        PRESCALER_RATIO_SELECT, DITHER_ENABLE, CP_THREE_STATE, BOOST_CURRENT_ON;
  logic        COUNTER_HOLD, OUTPUT_BUFFER_OFF, PFD_REF_PULSE, LOCK_DETECT;
  int          n_errors, n_checks, n_pulse, p0, seed;
  int          m_int, m_fraction_numerator, m_phase, m_mod, m_div, m_presc, p_phase, p_mod, p_div, m_lock;
  logic [31:0] ws [14] = '{32'h0004_0003, 32'h0802_8049, 32'h0025_8018, 32'h0025_0000, 32'h0004_8049,
    32'h0000_8049, 32'h000b_0000, 32'h000b_8008, 32'h0000_2002, 32'h0050_0004, 32'h0032_0000,
    32'h0000_0002, 32'h0020_0004, 32'hffff_fffd};
  int          exp_p [5] = '{6, 12, 3, 2, 0};

  sdlc_if u_sdlc_if ();
  sdlc_host u_sdlc_host (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SER(u_sdlc_if));
  sdlc_device u_sdlc_device (.CLK(CLK), .RST_B(RST_B), .SER(u_sdlc_if), .REF_IN(REF_IN), .FB_IN(FB_IN),
    .INT_VALUE(INT_VALUE), .FRACTION_NUMERATOR_VALUE(FRACTION_NUMERATOR_VALUE), .PHASE_WORD(PHASE_WORD),
    .FRACTION_MODULUS(FRACTION_MODULUS), .PRESCALER_RATIO_SELECT(PRESCALER_RATIO_SELECT),
    .OUT_DIVIDER_SELECT(OUT_DIVIDER_SELECT), .DITHER_ENABLE(DITHER_ENABLE),
    .TEST_OUTPUT_SELECT(TEST_OUTPUT_SELECT), .CP_CURRENT(CP_CURRENT), .CP_THREE_STATE(CP_THREE_STATE),
    .BOOST_CURRENT_ON(BOOST_CURRENT_ON), .COUNTER_HOLD(COUNTER_HOLD), .OUTPUT_BUFFER_OFF(OUTPUT_BUFFER_OFF),
    .PFD_REF_PULSE(PFD_REF_PULSE), .LOCK_DETECT(LOCK_DETECT));
  sdlc_link_props u_sdlc_link_props (.CLK(CLK), .RST_B(RST_B), .sclk(u_sdlc_if.sclk),
    .sdata(u_sdlc_if.sdata), .le(u_sdlc_if.le));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (PFD_REF_PULSE === 1'b1) begin
      n_pulse <= n_pulse + 1;
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waits on pready under a bound; the bus never assumes a fixed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    q = PRDATA;
    q_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      n_errors++;
      test_done();
    end
  endtask

  task automatic cmp_all();
    chk(INT_VALUE, m_int);
    chk(FRACTION_NUMERATOR_VALUE, m_fraction_numerator);
    chk(PHASE_WORD, m_phase);
    chk(FRACTION_MODULUS, m_mod);
    chk(PRESCALER_RATIO_SELECT, m_presc);
    chk(OUT_DIVIDER_SELECT, m_div);
    chk(DITHER_ENABLE, m_r2[30:29] == 2'h3);
    chk(TEST_OUTPUT_SELECT, m_r2[28:26]);
    chk(CP_CURRENT, m_r2[11:9]);
    chk(CP_THREE_STATE, m_r2[4] | m_r2[5]);
    chk(COUNTER_HOLD, m_r2[3] | m_r2[5]);
    chk(OUTPUT_BUFFER_OFF, m_r2[5]);
    chk(BOOST_CURRENT_ON, m_r3[18] & (m_lock == 0) & !(m_r2[3] | m_r2[5]));
  endtask

  task automatic send(input logic [31:0] w);
    logic ok;
    int k;
    ok = 1'b1;
    k = 0;
    if (w[2:0] == 3'h0) ok = (w[30:15] >= (m_presc ? 75 : 23));
    if (w[2:0] == 3'h1) ok = (w[26:15] < w[14:3]);
    if (ok) begin
      case (w[2:0])
        3'h0: begin
          m_int = w[30:15];
          m_fraction_numerator = w[14:3];
          m_phase = p_phase;
          m_mod = p_mod;
          if (m_r2[13]) m_div = p_div;
        end
        3'h1: begin
          m_presc = w[27];
          p_phase = w[26:15];
          p_mod = w[14:3];
        end
        3'h2: m_r2 = w;
        3'h3: m_r3 = w;
        3'h4: begin
          p_div = w[22:20];
          if (!m_r2[13]) m_div = w[22:20];
        end
        default: ;
      endcase
    end
    apb(1'b1, ADDR_WORD, w);
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    if (q[0] !== 1'b0) begin
      n_errors++;
      test_done();
    end
    repeat (8) @(posedge CLK);
    chk(q[2:0], {1'b0, !ok, 1'b0});
    if (!ok) apb(1'b1, ADDR_STATUS, 32'h6);
    cmp_all();
  endtask

  // feedback edge lands on the reference falling edge, so each pair is in the window
  task automatic ref_cycles(input int n, input logic fb);
    repeat (n) begin
      REF_IN <= 1'b1;
      FB_IN <= 1'b0;
      repeat (10) @(posedge CLK);
      REF_IN <= 1'b0;
      FB_IN <= fb;
      repeat (10) @(posedge CLK);
    end
  endtask

  function automatic logic [31:0] f2(input logic lock_cycle_count_select, pd, dbl, hv, crst, input logic [9:0] r);
    // window bit follows the count bit, so only recommended pairs go out
    f2 = {6'h00, dbl, hv, r, 5'h00, lock_cycle_count_select, lock_cycle_count_select, 1'b0, pd, 1'b0, crst, 3'h2};
  endfunction

  initial begin
    {RST_B, PSEL, PENABLE, PWRITE, REF_IN, FB_IN} = 6'h00;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    {m_r2, m_r3} = 64'h0;
    seed = 32'hcbd924b4;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    cmp_all();
    apb(1'b0, 8'h08, 32'h0);
    chk(q_err, 1'b1);
    apb(1'b0, ADDR_WORD, 32'h0);
    chk(q, WORD_RST);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      send({$random(seed)} & 32'hffff_fff8 | 32'h2);
    end
    $display("test random control words done");
    foreach (ws[i]) send(ws[i]);
    apb(1'b0, ADDR_WORD, 32'h0);
    chk(q, ws[13]);
    $display("test buffering and refusal done");
    for (int i = 0; i < 2; i++) begin
      send(f2(i == 0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h001));
      send(32'h0032_0000);
      ref_cycles(i == 0 ? 4 : 39, 1'b1);
      chk(LOCK_DETECT, 1'b0);
      ref_cycles(1, 1'b1);
      m_lock = 1;
      chk(LOCK_DETECT, 1'b1);
      cmp_all();
      if (i == 0) begin
        ref_cycles(1, 1'b0);
        m_lock = 0;
        chk(LOCK_DETECT, 1'b0);
      end
    end
    m_lock = 0;
    send(f2(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 10'h001));
    chk(LOCK_DETECT, 1'b0);
    $display("test lock detect done");
    for (int i = 0; i < 5; i++) begin
      send(f2(1'b0, 1'b0, i == 1, i == 2, i == 4, i == 3 ? 10'h003 : 10'h001));
      send(32'h0032_0000);
      p0 = n_pulse;
      ref_cycles(6, 1'b0);
      chk(n_pulse - p0, exp_p[i]);
    end
    $display("test reference path done");
    test_done();
  end
endmodule
